// ===== bench/rtgc_pin_model.sv
// pin-side partner model: drives the timer input and watches the timer output
module rtgc_pin_model (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // command from the bench
    input  wire logic gate_cmd,
    // timer pins
    input  wire logic timer_out,
    input  wire logic timer_out_en,
    output logic      timer_in,
    // observation
    output int        out_toggles
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] hold_q;
    logic       last_out_q;

    // ======================================================================
    // input pin
    // edges spaced four clocks
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            timer_in <= 1'b0;
            hold_q   <= 3'h0;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end else if (gate_cmd != timer_in) begin
            timer_in <= gate_cmd;
            hold_q   <= 3'h3;
        end
    end

    // ======================================================================
    // output pin: a level only counts while the block drives it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            last_out_q  <= 1'b0;
            out_toggles <= 0;
        end else begin
            last_out_q <= timer_out;
            if (timer_out_en && timer_out != last_out_q) begin
                out_toggles <= out_toggles + 1;
            end
        end
    end
endmodule : rtgc_pin_model

// ===== bench/tb_top.sv
// self-checking bench for the reloadable gated/compare timer
module tb_top
    import rtgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic             clk_sys    = 1'b0;
    logic             reset_n    = 1'b0;
    rtgc_bus_req_type bus_req    = '0;
    logic             gate_cmd   = 1'b0;
    logic [7:0]       bus_rdata;
    logic             timer_in;
    logic             timer_out;
    logic             timer_out_en;
    logic             timer_irq;
    int               out_toggles;
    int               bad_count  = 0;
    int               num_checks = 0;

    always #5 clk_sys = ~clk_sys;

    rtgc_timer u_rtgc_timer (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .bus_req     (bus_req),
        .bus_rdata   (bus_rdata),
        .timer_in    (timer_in),
        .timer_out   (timer_out),
        .timer_out_en(timer_out_en),
        .timer_irq   (timer_irq)
    );

    rtgc_pin_model u_rtgc_pin_model (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .gate_cmd    (gate_cmd),
        .timer_out   (timer_out),
        .timer_out_en(timer_out_en),
        .timer_in    (timer_in),
        .out_toggles (out_toggles)
    );

    // ======================================================================
    // shared tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_wr(input logic [2:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask : reg_wr

    // read data appear in the cycle after the strobe edge and hold until the next read
    task automatic reg_rd(input logic [2:0] addr, output logic [7:0] data);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk_sys);
        bus_req <= '0;
        #1;
        data = bus_rdata;
    endtask : reg_rd

    task automatic setup(input logic [7:0] ctl, input logic [15:0] count, input logic [15:0] reload);
        reg_wr(ADDR_CTL1, ctl & 8'h7f);
        reg_wr(ADDR_COUNT_HI, count[15:8]);
        reg_wr(ADDR_COUNT_LO, count[7:0]);
        reg_wr(ADDR_RELOAD_HI, reload[15:8]);
        reg_wr(ADDR_RELOAD_LO, reload[7:0]);
    endtask : setup

    task automatic wait_irq(input int limit, output int cycles);
        cycles = 0;
        do begin
            @(posedge clk_sys);
            #1;
            cycles++;
        end while (timer_irq !== 1'b1 && cycles < limit);
        check("irq seen", {15'h0, timer_irq}, 16'h0001);
    endtask : wait_irq

    // ======================================================================
    // scenarios
    task automatic reset_values;
        logic [7:0] d;
        logic [7:0] exp [8] = '{8'h00, 8'h01, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            reg_rd(3'(i), d);
            check("reset value", {8'h00, d}, {8'h00, exp[i]});
        end
    endtask : reset_values

    task automatic prescale_sweep;
        int c;
        int t0;
        for (int p = 0; p < 8; p++) begin
            setup({2'b10, 3'(p), MODE_COMPARE}, COUNT_ONE, 16'h0002);
            reg_wr(ADDR_CTL0, 8'h01);
            reg_wr(ADDR_CTL1, {2'b10, 3'(p), MODE_COMPARE});
            wait_irq(2000, c);
            t0 = out_toggles;
            wait_irq(2000, c);
            check("compare period", 16'(c), 16'(2 << p));
            check("out toggles", 16'(out_toggles), 16'(t0 + 1));
            check("out enable", {15'h0, timer_out_en}, 16'h0001);
        end
    endtask : prescale_sweep

    task automatic rollover;
        logic [15:0] start [3] = '{16'hfffe, 16'h0000, 16'hfffe};
        logic [15:0] rel [3]   = '{16'h0002, 16'h0002, 16'h0000};
        int          c [3];
        for (int i = 0; i < 3; i++) begin
            setup({2'b10, 3'h0, MODE_CONTINUOUS}, start[i], rel[i]);
            reg_wr(ADDR_CTL1, {2'b10, 3'h0, MODE_CONTINUOUS});
            wait_irq(100, c[i]);
        end
        check("rollover extra", 16'(c[0] - c[1]), 16'h0002);
        check("reload zero", 16'(c[2]), 16'(c[1]));
    endtask : rollover

    task automatic gated_mode;
        logic [7:0] d;
        int         c;
        int         n;
        setup({2'b11, 3'h0, MODE_GATED}, 16'h0008, 16'h000a);
        reg_wr(ADDR_CTL0, 8'h03);
        reg_wr(ADDR_CTL1, {2'b11, 3'h0, MODE_GATED});
        repeat (20) @(posedge clk_sys);
        reg_rd(ADDR_COUNT_LO, d);
        check("held count", {8'h00, d}, 16'h0008);
        @(posedge clk_sys);
        gate_cmd <= 1'b1;
        wait_irq(40, c);
        wait_irq(40, c);
        check("gated period", 16'(c), 16'h000a);
        // drop the gate right after a reload so the two events cannot meet
        @(posedge clk_sys);
        gate_cmd <= 1'b0;
        wait_irq(8, c);
        n = 0;
        repeat (30) begin
            @(posedge clk_sys);
            #1;
            if (timer_irq === 1'b1) n++;
        end
        check("no irq gated off", 16'(n), 16'h0000);
        reg_rd(ADDR_CTL0, d);
        check("pin vs polarity", {15'h0, d[7]}, 16'h0000);
        reg_wr(ADDR_CTL1, {2'b10, 3'h0, MODE_GATED});
        wait_irq(20, c);
        reg_wr(ADDR_CTL1, 8'h00);
    endtask : gated_mode

    // ======================================================================
    // run control
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        reset_values();
        prescale_sweep();
        rollover();
        gated_mode();
        report_and_stop();
    end

    // the whole sequence needs well under ten thousand clocks
    initial begin
        #400us;
        bad_count++;
        $display("BAD watchdog expected finish seen timeout");
        report_and_stop();
    end
endmodule : tb_top

// ===== logic/rtgc_pkg.sv
// constants, register layout and types of the reloadable gated/compare timer
// ==========================================================================
// How it works
// - one independent 16-bit reloadable up-counter per timer instance
// - prescaler divides the system clock by a power of two from 1 to 128
// - count at all ones without reload rolls over to zero and continues
// - reload one with prescale 1 is shortest; reload zero with 128 is longest
// - compare mode always counts the prescaled system clock, never the input
// - compare time equals (compare minus start plus one) times prescale clock periods
// - gated mode advances only while the input is at its selected active level
// - gated mode raises the interrupt on input deassertion or on reload
// - gated mode counts the prescaled clock; the input only gates it
// - on reaching reload: interrupt, count becomes one, resume if gate active
// - timer output toggles on every reload when its output function is on
// - software start count applies to first pass only; later passes start at one
// - enabling the timer starts counting from the current count value
// - after reset reload reads all ones, count low reads one, others zero
package rtgc_pkg;

    // ======================================================================
    // register map (byte registers, 3-bit index)
    localparam logic [2:0] ADDR_COUNT_HI  = 3'h0;
    localparam logic [2:0] ADDR_COUNT_LO  = 3'h1;
    localparam logic [2:0] ADDR_RELOAD_HI = 3'h2;
    localparam logic [2:0] ADDR_RELOAD_LO = 3'h3;
    localparam logic [2:0] ADDR_PWM_HI    = 3'h4;
    localparam logic [2:0] ADDR_PWM_LO    = 3'h5;
    localparam logic [2:0] ADDR_CTL0      = 3'h6;
    localparam logic [2:0] ADDR_CTL1      = 3'h7;

    // ======================================================================
    // reset values
    localparam logic [15:0] RST_COUNT  = 16'h0001;
    localparam logic [15:0] RST_RELOAD = 16'hffff;
    localparam logic [15:0] RST_PWM    = 16'h0000;
    localparam logic [15:0] COUNT_ONE  = 16'h0001;
    localparam logic [15:0] COUNT_ONES = 16'hffff;

    // ======================================================================
    // control field positions
    localparam int CTL1_EN_BIT   = 7;
    localparam int CTL1_POL_BIT  = 6;
    localparam int CTL1_PRE_MSB  = 5;
    localparam int CTL1_PRE_LSB  = 3;
    localparam int CTL1_MODE_MSB = 2;
    localparam int CTL1_MODE_LSB = 0;
    localparam int CTL0_OUT_BIT  = 0;
    localparam int CTL0_IN_BIT   = 1;
    localparam int CTL0_PIN_BIT  = 7;

    // ======================================================================
    // modes
    localparam logic [2:0] MODE_CONTINUOUS = 3'h1;
    localparam logic [2:0] MODE_COMPARE    = 3'h3;
    localparam logic [2:0] MODE_GATED      = 3'h6;

    localparam int PRE_W = 7;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } rtgc_bus_req_type;

    typedef struct packed {
        logic       enable;
        logic       polarity;
        logic [2:0] prescale;
        logic [2:0] mode;
    } rtgc_ctl1_type;

endpackage : rtgc_pkg

// ===== logic/rtgc_prescaler.sv
// power-of-two prescaler that holds its count while counting is not allowed
module rtgc_prescaler
    import rtgc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // control
    input  wire logic       run,
    input  wire logic [2:0] prescale,
    // output
    output logic            tick
);

    logic [PRE_W-1:0] cnt_q;
    logic [PRE_W-1:0] cnt_d;
    logic [PRE_W-1:0] last;

    // ======================================================================
    // divide
    always_comb begin
        last  = PRE_W'((8'h01 << prescale) - 8'h01);
        // terminal count from prescale
        // at or past the end, so a count held under a larger prescale cannot stall a smaller one
        tick  = run && (cnt_q >= last);
        cnt_d = cnt_q;
        if (run) begin
            cnt_d = tick ? '0 : PRE_W'(cnt_q + 1'b1);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ======================================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_div_one_every: assert property ((run && prescale == 3'h0) |-> tick)
        else $error("divide by one must tick every running cycle");
    a_div_gap_tick: assert property ((tick && prescale != 3'h0) |=> !tick)
        else $error("prescale above one ticked twice in a row");

endmodule : rtgc_prescaler

// ===== logic/rtgc_timer.sv
// 16-bit reloadable timer with compare and gated modes, byte register port
module rtgc_timer
    import rtgc_pkg::*;
(
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // register port
    input  wire rtgc_bus_req_type bus_req,
    output logic [7:0]            bus_rdata,
    // timer pins
    input  wire logic             timer_in,
    output logic                  timer_out,
    output logic                  timer_out_en,
    // event
    output logic                  timer_irq
);

    // ======================================================================
    // state
    // 16-bit reloadable up-count
    logic [15:0]   count_q;
    logic [15:0]   count_d;
    logic [15:0]   reload_q;
    logic [15:0]   reload_d;
    logic [15:0]   pwm_q;
    logic [15:0]   pwm_d;
    logic [7:0]    ctl0_q;
    logic [7:0]    ctl0_d;
    rtgc_ctl1_type ctl1_q;
    rtgc_ctl1_type ctl1_d;
    logic [7:0]    rdata_d;
    logic          tout_q;
    logic          tout_d;
    logic          irq_q;
    logic          irq_d;

    // input synchroniser and gate history
    logic          in_meta_q;
    logic          in_sync_q;
    logic          active_q;
    logic          active;

    // control decode
    logic          gated;
    logic          compare;
    logic          run;
    logic          pre_tick;
    logic          hit;
    logic          count_wr;
    logic          gate_fall;
    logic          wr_sel;

    // ======================================================================
    // timer input: two flops before any logic sees it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            in_meta_q <= 1'b0;
            in_sync_q <= 1'b0;
        end else begin
            in_meta_q <= timer_in;
            in_sync_q <= in_meta_q;
        end
    end

    // ======================================================================
    // counting conditions
    always_comb begin
        gated   = (ctl1_q.mode == MODE_GATED);
        compare = (ctl1_q.mode == MODE_COMPARE);
        // polarity bit selects the active level of the gate
        active  = ctl0_q[CTL0_IN_BIT] && (in_sync_q == ctl1_q.polarity);
        // compare and continuous ignore the pin; gated uses it only as gate
        // disabled or gated off stops the prescaler too
        run     = ctl1_q.enable && (!gated || active);
        // compare value is the reload pair
        // reload zero matches only after the wrap, the longest period
        hit     = (count_q == reload_q);
        // gate going inactive while enabled in gated mode
        gate_fall = ctl1_q.enable && gated && active_q && !active;
        count_wr  = bus_req.wr && (bus_req.addr == ADDR_COUNT_HI || bus_req.addr == ADDR_COUNT_LO);
    end

    rtgc_prescaler u_prescaler (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .run      (run),
        .prescale (ctl1_q.prescale),
        .tick     (pre_tick)
    );

    // ======================================================================
    // counter, output pin and interrupt
    always_comb begin
        count_d = count_q;
        tout_d  = tout_q;
        irq_d   = gate_fall;
        if (pre_tick) begin
            if (hit) begin
                // reload: count restarts at one and interrupt is raised
                // every later pass therefore begins at one
                count_d = COUNT_ONE;
                irq_d   = 1'b1;
                // output toggles on each reload when enabled
                if (ctl0_q[CTL0_OUT_BIT]) begin
                    tout_d = ~tout_q;
                end
            end else begin
                // plain add wraps all ones to zero
                count_d = count_q + COUNT_ONE;
            end
        end
        // software write of the count beats a concurrent tick
        if (bus_req.wr && bus_req.addr == ADDR_COUNT_HI) begin
            count_d[15:8] = bus_req.wdata;
        end
        if (bus_req.wr && bus_req.addr == ADDR_COUNT_LO) begin
            count_d[7:0] = bus_req.wdata;
        end
    end

    // ======================================================================
    // configuration registers
    always_comb begin
        reload_d = reload_q;
        pwm_d    = pwm_q;
        ctl0_d   = ctl0_q;
        ctl1_d   = ctl1_q;
        wr_sel   = bus_req.wr;
        if (wr_sel) begin
            case (bus_req.addr)
                ADDR_RELOAD_HI: reload_d[15:8] = bus_req.wdata;
                ADDR_RELOAD_LO: reload_d[7:0]  = bus_req.wdata;
                ADDR_PWM_HI:    pwm_d[15:8]    = bus_req.wdata;
                ADDR_PWM_LO:    pwm_d[7:0]     = bus_req.wdata;
                ADDR_CTL0: begin
                    ctl0_d[CTL0_OUT_BIT] = bus_req.wdata[CTL0_OUT_BIT];
                    ctl0_d[CTL0_IN_BIT]  = bus_req.wdata[CTL0_IN_BIT];
                end
                // enabling only releases the count; the value is kept
                ADDR_CTL1:      ctl1_d = rtgc_ctl1_type'(bus_req.wdata);
                default: begin
                end
            endcase
        end
    end

    // ======================================================================
    // read mux, data one cycle after the strobe
    always_comb begin
        rdata_d = bus_rdata;
        if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_COUNT_HI:  rdata_d = count_q[15:8];
                ADDR_COUNT_LO:  rdata_d = count_q[7:0];
                ADDR_RELOAD_HI: rdata_d = reload_q[15:8];
                ADDR_RELOAD_LO: rdata_d = reload_q[7:0];
                ADDR_PWM_HI:    rdata_d = pwm_q[15:8];
                ADDR_PWM_LO:    rdata_d = pwm_q[7:0];
                // live pin level lets software tell the interrupt cause
                ADDR_CTL0: begin
                    rdata_d               = ctl0_q;
                    rdata_d[CTL0_PIN_BIT] = in_sync_q;
                end
                ADDR_CTL1:      rdata_d = ctl1_q;
                default:        rdata_d = 8'h00;
            endcase
        end
    end

    // ======================================================================
    // registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            // reload all ones, count low one, the rest zero
            count_q   <= RST_COUNT;
            reload_q  <= RST_RELOAD;
            pwm_q     <= RST_PWM;
            ctl0_q    <= 8'h00;
            ctl1_q    <= '0;
            bus_rdata <= 8'h00;
            tout_q    <= 1'b0;
            irq_q     <= 1'b0;
            active_q  <= 1'b0;
        end else begin
            count_q   <= count_d;
            reload_q  <= reload_d;
            pwm_q     <= pwm_d;
            ctl0_q    <= ctl0_d;
            ctl1_q    <= ctl1_d;
            bus_rdata <= rdata_d;
            tout_q    <= tout_d;
            irq_q     <= irq_d;
            active_q  <= active;
        end
    end

    assign timer_out    = tout_q;
    assign timer_out_en = ctl0_q[CTL0_OUT_BIT];
    assign timer_irq    = irq_q;

    // ======================================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // ======================================================================
    // counter checks

    a_roll_over_zero: assert property (
        (pre_tick && count_q == COUNT_ONES && !hit && !count_wr)
        |=> count_q == 16'h0000)
        else $error("count did not roll over to zero");

    a_zero_reload_long: assert property (
        (pre_tick && reload_q == 16'h0000 && count_q == COUNT_ONES && !count_wr)
        |=> count_q == 16'h0000)
        else $error("zero reload cut the period short");

    a_reload_to_one: assert property (
        (pre_tick && hit && !count_wr)
        |=> (count_q == COUNT_ONE) && timer_irq)
        else $error("reload did not restart at one with interrupt");

    a_compare_counts: assert property (
        (compare && ctl1_q.enable && pre_tick && !hit && !count_wr)
        |=> count_q == $past(count_q) + COUNT_ONE)
        else $error("compare mode did not count the clock");

    a_gated_counts: assert property (
        (gated && active && ctl1_q.enable && ctl1_q.prescale == 3'h0 && !hit && !count_wr)
        |=> count_q == $past(count_q) + COUNT_ONE)
        else $error("open gate did not count the clock");

    a_hold_disabled: assert property (
        (!ctl1_q.enable && !count_wr)
        |=> $stable(count_q))
        else $error("count moved while disabled");

    a_gate_holds: assert property (
        (gated && !active && !count_wr)
        |=> $stable(count_q))
        else $error("count moved with gate inactive");

    a_enable_keeps_count: assert property (
        (!ctl1_q.enable && !count_wr && bus_req.wr && bus_req.addr == ADDR_CTL1)
        |=> count_q == $past(count_q))
        else $error("enabling changed the count");

    a_count_write_lo: assert property (
        (bus_req.wr && bus_req.addr == ADDR_COUNT_LO)
        |=> count_q[7:0] == $past(bus_req.wdata))
        else $error("count low write was lost");

    // ======================================================================
    // pin and event checks

    a_sync_two_flops: assert property (
        in_sync_q == $past(in_meta_q))
        else $error("gate synchroniser skipped a stage");

    a_irq_cause: assert property (
        timer_irq
        |-> $past(gate_fall || (pre_tick && hit)))
        else $error("interrupt without reload or gate deassertion");

    a_gate_fall_irq: assert property (
        gate_fall
        |=> timer_irq)
        else $error("gate deassertion raised no interrupt");

    a_out_toggles: assert property (
        (pre_tick && hit && ctl0_q[CTL0_OUT_BIT])
        |=> timer_out != $past(timer_out))
        else $error("output pin did not toggle on reload");

    a_out_steady: assert property (
        !(pre_tick && hit)
        |=> $stable(timer_out))
        else $error("output pin moved without a reload");

    // ======================================================================
    // register port checks

    // read data one cycle after the strobe
    a_read_count_lo: assert property (
        (bus_req.rd && bus_req.addr == ADDR_COUNT_LO)
        |=> bus_rdata == $past(count_q[7:0]))
        else $error("count low read data wrong");

    a_read_pin_level: assert property (
        (bus_req.rd && bus_req.addr == ADDR_CTL0)
        |=> bus_rdata[CTL0_PIN_BIT] == $past(in_sync_q))
        else $error("pin level read back wrong");

    // ======================================================================
    // main scenarios
    c_reload_event: cover property (pre_tick && hit);
    c_gate_fall: cover property (gate_fall);
    c_wrap: cover property (pre_tick && count_q == COUNT_ONES && !hit);
    c_gated_reload: cover property (gated && pre_tick && hit);
    c_out_toggle: cover property (pre_tick && hit && ctl0_q[CTL0_OUT_BIT]);

endmodule : rtgc_timer
